// File: shared/afc_pkg.sv
// Constants, carrier structs and state types of the serial frame codec.
// Assumes a 50 MHz pclk and byte-wide streams on both the host and radio sides.
package afc_pkg;
	localparam logic [11:0] ADDR_CTRL  = 12'h000;
	localparam logic [11:0] ADDR_SP    = 12'h004;
	localparam logic [11:0] ADDR_STAT  = 12'h008;
	localparam int          CTRL_COMMIT = 4;
	localparam logic [1:0]  MODE_TRANS = 2'h0;
	localparam logic [1:0]  MODE_API   = 2'h1;
	localparam logic [1:0]  MODE_ESC   = 2'h2;
	localparam logic [7:0]  DELIM      = 8'h7e;
	localparam logic [7:0]  ESC        = 8'h7d;
	localparam logic [7:0]  XON        = 8'h11;
	localparam logic [7:0]  XOFF       = 8'h13;
	localparam logic [7:0]  ESC_XOR    = 8'h20;
	localparam logic [7:0]  CK_OK      = 8'hff;
	localparam logic [7:0]  K_TX64     = 8'h00;
	localparam logic [7:0]  K_TX16     = 8'h01;
	localparam logic [7:0]  K_CMD      = 8'h08;
	localparam logic [7:0]  K_QCMD     = 8'h09;
	localparam logic [7:0]  K_RCMD     = 8'h17;
	localparam logic [7:0]  K_RX64     = 8'h80;
	localparam logic [7:0]  K_RX16     = 8'h81;
	localparam logic [7:0]  K_IO64     = 8'h82;
	localparam logic [7:0]  K_CRSP     = 8'h88;
	localparam logic [7:0]  K_TXST     = 8'h89;
	localparam logic [7:0]  K_MST      = 8'h8a;
	localparam logic [7:0]  K_RRSP     = 8'h97;
	localparam logic [15:0] CMD_COMMIT = 16'h4143;
	localparam logic [7:0]  STAT_OK    = 8'h00;
	localparam logic [1:0]  ST_OK      = 2'h0;
	localparam logic [1:0]  ST_BCALT   = 2'h2;
	localparam logic [1:0]  ST_TIMEOUT = 2'h3;
	localparam int          BUF_N      = 64;
	localparam logic [15:0] BUF_LEN    = 16'h0040;
	localparam int          OB_N       = 9;
	localparam logic [15:0] RD_LEN     = 16'h0009;
	localparam logic [15:0] WR_LEN     = 16'h0005;
	localparam int          TICK_MS    = 10;
	localparam int          CLK_HZ     = 50000000;
	localparam int          TICK_CYC   = TICK_MS * (CLK_HZ / 1000);
	localparam logic [18:0] TO_NUM     = 19'h00005;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} afc_byte_t;
	typedef struct packed {
		logic        valid;
		logic        src64;
		logic        io;
		logic        remote;
		logic [15:0] len;
		logic [7:0]  data;
	} afc_rrx_t;
	typedef struct packed {
		logic       valid;
		logic       bcast;
		logic [1:0] status;
		logic [7:0] fid;
	} afc_txd_t;
	typedef struct packed {
		logic       valid;
		logic [7:0] code;
	} afc_mst_t;
	typedef struct packed {
		logic        wr;
		logic        apply;
		logic [15:0] name;
		logic [31:0] val;
	} afc_par_t;

	typedef enum logic [1:0] {R_HUNT = 2'b00, R_LH = 2'b01, R_DATA = 2'b10, R_CK = 2'b11} afc_rx_t;
	typedef enum logic [1:0] {D_IDLE = 2'b00, D_GO = 2'b01, D_RSP = 2'b10, D_RADIO = 2'b11} afc_d_t;
	typedef enum logic [2:0] {T_IDLE = 3'b000, T_DELIM = 3'b001, T_LH = 3'b010, T_LL = 3'b011,
		T_BODY = 3'b100, T_CK = 3'b101} afc_tx_t;

	typedef struct packed {
		logic [1:0]                mode;
		logic [15:0]               sp;
		afc_rx_t                   rs;
		logic                      rlo;
		logic                      resc;
		logic [15:0]               rlen;
		logic [15:0]               ridx;
		logic [7:0]                rsum;
		logic [BUF_N-1:0][7:0]     buff;
		afc_d_t                    ds;
		logic [15:0]               didx;
		afc_tx_t                   ts;
		logic                      tradio;
		logic                      tesc;
		logic [15:0]               tlen;
		logic [15:0]               tidx;
		logic [7:0]                tsum;
		logic [OB_N-1:0][7:0]      ob;
		afc_byte_t                 hout;
		afc_byte_t                 rtx;
		afc_par_t                  par;
		logic                      pend;
		logic                      abort;
		logic                      ts_pend;
		logic [7:0]                ts_fid;
		logic [1:0]                ts_code;
		logic                      ms_pend;
		logic [7:0]                ms_code;
		logic                      to_pend;
		logic [7:0]                to_fid;
		logic [18:0]               tick;
		logic [18:0]               ticks;
		logic [7:0]                good;
		logic [7:0]                bad;
		logic                      rok;
		logic [31:0]               prdata;
	} afc_st_t;

	function automatic logic need_esc(logic [7:0] b);
		return b == DELIM || b == ESC || b == XON || b == XOFF;
	endfunction
endpackage

// File: design/afc_codec.sv
// Serial frame codec: transparent pass-through or delimited, checksummed frames between host and radio.
// Assumes a UART and a radio datapath on pclk outside, both speaking byte streams with valid and ready.
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
module afc_codec #(
	parameter int TICK_CYC = afc_pkg::TICK_CYC
) (
	input  logic               pclk,
	input  logic               presetn,
	input  logic               ce,
	input  logic               psel,
	input  logic               penable,
	input  logic               pwrite,
	input  logic [11:0]        paddr,
	input  logic [31:0]        pwdata,
	output logic [31:0]        prdata,
	output logic               pready,
	output logic               pslverr,
	input  afc_pkg::afc_byte_t hin,
	output logic               hin_ready,
	output afc_pkg::afc_byte_t hout,
	input  logic               hout_ready,
	output afc_pkg::afc_byte_t rtx,
	input  logic               rtx_ready,
	input  afc_pkg::afc_rrx_t  rrx,
	output logic               rrx_ready,
	input  afc_pkg::afc_txd_t  txdone,
	input  afc_pkg::afc_mst_t  mstat,
	input  logic               ind_pending,
	input  logic [7:0]         ind_fid,
	output logic               ind_abort,
	output afc_pkg::afc_par_t  par,
	input  logic [31:0]        par_rd_data
);
	localparam logic [18:0] TICK_LAST = 19'(TICK_CYC - 1);

	afc_pkg::afc_st_t s, n;
	logic        otake, rtake, hin_rdy, rrx_rdy, wr_hit, rx_tok, esc_now, src_ok, go, rdq;
	logic [7:0]  rx_v, rx_ck, kind, cur;
	logic [18:0] to_limit;

	assign wr_hit = psel && penable && pwrite && pready;
	assign kind   = s.buff[0];
	// Length bytes are unescaped like payload bytes: the unescaped rx_v, not the raw byte value, decides.
	assign rx_v   = s.resc ? hin.data ^ afc_pkg::ESC_XOR : hin.data;
	assign rx_tok = !(s.mode == afc_pkg::MODE_ESC && (hin.data == afc_pkg::DELIM
		|| (hin.data == afc_pkg::ESC && !s.resc)));
	assign rx_ck  = s.rsum + rx_v;
	assign to_limit = 19'(({3'h0, s.sp} * afc_pkg::TO_NUM) >> 1);

	always_comb begin
		n = s;
		n.par.wr = 1'b0;
		n.par.apply = 1'b0;
		n.abort = 1'b0;
		otake = !s.hout.valid || hout_ready;
		rtake = !s.rtx.valid || rtx_ready;
		hin_rdy = 1'b0;
		rrx_rdy = 1'b0;
		esc_now = 1'b0;
		src_ok = 1'b1;
		go = 1'b0;
		rdq = s.rlen <= 16'h0004;
		cur = afc_pkg::DELIM;
		if (otake) n.hout.valid = 1'b0;
		if (rtake) n.rtx.valid = 1'b0;

		if (s.mode == afc_pkg::MODE_TRANS) begin
			hin_rdy = rtake;
			if (hin.valid && rtake) n.rtx = '{1'b1, 1'b1, hin.data};
			rrx_rdy = otake;
			if (rrx.valid && otake) n.hout = '{1'b1, 1'b0, rrx.data};
		end else begin
			// The frame buffer is single: the host is held off while a frame is dispatched.
			hin_rdy = s.ds == afc_pkg::D_IDLE;
			if (hin.valid && hin_rdy) begin
				if (s.mode == afc_pkg::MODE_ESC && hin.data == afc_pkg::DELIM) begin
					if (s.rs != afc_pkg::R_HUNT) n.bad = s.bad + 8'h01;
					n.rs = afc_pkg::R_LH;
					n.rlo = 1'b0;
					n.resc = 1'b0;
				end else if (s.rs == afc_pkg::R_HUNT) begin
					if (hin.data == afc_pkg::DELIM) begin
						n.rs = afc_pkg::R_LH;
						n.rlo = 1'b0;
					end
				end else if (!rx_tok) begin
					n.resc = 1'b1;
				end else begin
					n.resc = 1'b0;
					case (s.rs)
						afc_pkg::R_LH: begin
							n.rlo = 1'b1;
							if (!s.rlo) begin
								n.rlen[15:8] = rx_v;
							end else begin
								n.rlen[7:0] = rx_v;
								n.ridx = 16'h0000;
								n.rsum = 8'h00;
								n.rs = afc_pkg::R_DATA;
								if ({s.rlen[15:8], rx_v} == 16'h0000 || {s.rlen[15:8], rx_v} > afc_pkg::BUF_LEN) begin
									n.rs = afc_pkg::R_HUNT;
									n.bad = s.bad + 8'h01;
								end
							end
						end
						afc_pkg::R_DATA: begin
							n.buff[s.ridx[5:0]] = rx_v;
							n.rsum = rx_ck;
							n.ridx = s.ridx + 16'h0001;
							if (n.ridx == s.rlen) n.rs = afc_pkg::R_CK;
						end
						afc_pkg::R_CK: begin
							n.rs = afc_pkg::R_HUNT;
							if (rx_ck == afc_pkg::CK_OK) begin
								n.ds = afc_pkg::D_GO;
								n.good = s.good + 8'h01;
							end else begin
								n.bad = s.bad + 8'h01;
							end
						end
						default: n.rs = afc_pkg::R_HUNT;
					endcase
				end
			end

			case (s.ds)
				afc_pkg::D_GO: begin
					n.ds = afc_pkg::D_IDLE;
					n.didx = 16'h0000;
					case (kind)
						afc_pkg::K_TX64, afc_pkg::K_TX16, afc_pkg::K_RCMD: n.ds = afc_pkg::D_RADIO;
						afc_pkg::K_CMD, afc_pkg::K_QCMD: begin
							n.ds = afc_pkg::D_RSP;
							n.par.name = {s.buff[2], s.buff[3]};
							n.par.wr = !rdq;
							n.par.val = 32'h00000000;
							for (int i = 4; i < 8; i++) begin
								if (16'(i) < s.rlen) n.par.val = {n.par.val[23:0], s.buff[i]};
							end
							if (kind == afc_pkg::K_CMD || n.par.name == afc_pkg::CMD_COMMIT) begin
								n.par.apply = 1'b1;
								n.pend = 1'b0;
							end else if (!rdq) begin
								n.pend = 1'b1;
							end
						end
						default: n.ds = afc_pkg::D_IDLE;
					endcase
				end
				afc_pkg::D_RSP: begin
					// The read value is sampled here, one cycle after the name went out.
					if (s.ts == afc_pkg::T_IDLE) begin
						n.ob[0] = afc_pkg::K_CRSP;
						n.ob[1] = s.buff[1];
						n.ob[2] = s.buff[2];
						n.ob[3] = s.buff[3];
						n.ob[4] = afc_pkg::STAT_OK;
						n.ob[5] = par_rd_data[31:24];
						n.ob[6] = par_rd_data[23:16];
						n.ob[7] = par_rd_data[15:8];
						n.ob[8] = par_rd_data[7:0];
						n.tlen = rdq ? afc_pkg::RD_LEN : afc_pkg::WR_LEN;
						n.tradio = 1'b0;
						n.ds = afc_pkg::D_IDLE;
						go = 1'b1;
					end
				end
				afc_pkg::D_RADIO: begin
					if (rtake) begin
						n.rtx = '{1'b1, s.didx + 16'h0001 == s.rlen, s.buff[s.didx[5:0]]};
						n.didx = s.didx + 16'h0001;
						if (n.rtx.last) n.ds = afc_pkg::D_IDLE;
					end
				end
				default: ;
			endcase

			if (s.ts == afc_pkg::T_IDLE) begin
				if (s.ds != afc_pkg::D_RSP) begin
					n.tradio = 1'b0;
					go = 1'b1;
					if (s.to_pend) begin
						n.to_pend = 1'b0;
						n.ob[0] = afc_pkg::K_TXST;
						n.ob[1] = s.to_fid;
						n.ob[2] = {6'h00, afc_pkg::ST_TIMEOUT};
						n.tlen = 16'h0003;
					end else if (s.ts_pend) begin
						n.ts_pend = 1'b0;
						n.ob[0] = afc_pkg::K_TXST;
						n.ob[1] = s.ts_fid;
						n.ob[2] = {6'h00, s.ts_code};
						n.tlen = 16'h0003;
					end else if (s.ms_pend) begin
						n.ms_pend = 1'b0;
						n.ob[0] = afc_pkg::K_MST;
						n.ob[1] = s.ms_code;
						n.tlen = 16'h0002;
					end else if (rrx.valid) begin
						n.ob[0] = rrx.remote ? afc_pkg::K_RRSP : !rrx.src64 ? afc_pkg::K_RX16
							: rrx.io ? afc_pkg::K_IO64 : afc_pkg::K_RX64;
						n.tlen = rrx.len + 16'h0001;
						n.tradio = 1'b1;
					end else begin
						go = 1'b0;
					end
				end
			end else if (otake) begin
				case (s.ts)
					afc_pkg::T_LH: cur = s.tlen[15:8];
					afc_pkg::T_LL: cur = s.tlen[7:0];
					afc_pkg::T_BODY: cur = (s.tradio && s.tidx != 16'h0000) ? rrx.data : s.ob[s.tidx[3:0]];
					afc_pkg::T_CK: cur = afc_pkg::CK_OK - s.tsum;
					default: cur = afc_pkg::DELIM;
				endcase
				src_ok = !(s.ts == afc_pkg::T_BODY && s.tradio && s.tidx != 16'h0000) || rrx.valid;
				esc_now = s.mode == afc_pkg::MODE_ESC && s.ts != afc_pkg::T_DELIM && afc_pkg::need_esc(cur)
					&& !s.tesc;
				if (src_ok) begin
					n.hout.valid = 1'b1;
					n.hout.last = 1'b0;
					if (esc_now) begin
						n.hout.data = afc_pkg::ESC;
						n.tesc = 1'b1;
					end else begin
						n.hout.data = s.tesc ? cur ^ afc_pkg::ESC_XOR : cur;
						n.tesc = 1'b0;
						case (s.ts)
							afc_pkg::T_DELIM: n.ts = afc_pkg::T_LH;
							afc_pkg::T_LH: n.ts = afc_pkg::T_LL;
							afc_pkg::T_LL: n.ts = afc_pkg::T_BODY;
							afc_pkg::T_BODY: begin
								rrx_rdy = s.tradio && s.tidx != 16'h0000;
								n.tsum = s.tsum + cur;
								n.tidx = s.tidx + 16'h0001;
								if (n.tidx == s.tlen) n.ts = afc_pkg::T_CK;
							end
							default: begin
								n.hout.last = 1'b1;
								n.ts = afc_pkg::T_IDLE;
							end
						endcase
					end
				end
			end
			if (go) begin
				n.ts = afc_pkg::T_DELIM;
				n.tidx = 16'h0000;
				n.tsum = 8'h00;
				n.tesc = 1'b0;
			end
		end

		// The long timeout is counted in 10 ms ticks so the counters stay narrow.
		if (ind_pending && s.sp != 16'h0000) begin
			n.tick = s.tick + 19'h00001;
			if (s.tick == TICK_LAST) begin
				n.tick = 19'h00000;
				n.ticks = s.ticks + 19'h00001;
			end
			if (s.ticks >= to_limit) begin
				n.to_pend = 1'b1;
				n.to_fid = ind_fid;
				n.abort = 1'b1;
				n.tick = 19'h00000;
				n.ticks = 19'h00000;
			end
		end else begin
			n.tick = 19'h00000;
			n.ticks = 19'h00000;
		end

		// Event capture sits last so an arrival beats the clear of the same cycle.
		if (txdone.valid) begin
			n.ts_pend = 1'b1;
			n.ts_fid = txdone.fid;
			n.ts_code = (txdone.bcast && txdone.status != afc_pkg::ST_BCALT) ? afc_pkg::ST_OK : txdone.status;
		end
		if (mstat.valid) begin
			n.ms_pend = 1'b1;
			n.ms_code = mstat.code;
		end

		n.rok = psel && !(penable && s.rok);
		if (psel) begin
			case (paddr)
				afc_pkg::ADDR_CTRL: n.prdata = {30'h00000000, s.mode};
				afc_pkg::ADDR_SP: n.prdata = {16'h0000, s.sp};
				afc_pkg::ADDR_STAT: n.prdata = {8'h00, s.bad, s.good, 5'h00, s.ts != afc_pkg::T_IDLE,
					s.rs != afc_pkg::R_HUNT, s.pend};
				default: n.prdata = 32'h00000000;
			endcase
		end
		if (wr_hit) begin
			case (paddr)
				afc_pkg::ADDR_CTRL: begin
					// A mode change abandons any half-seen or half-sent frame.
					if (pwdata[1:0] <= afc_pkg::MODE_ESC && pwdata[1:0] != s.mode) begin
						n.mode = pwdata[1:0];
						n.rs = afc_pkg::R_HUNT;
						n.ds = afc_pkg::D_IDLE;
						n.ts = afc_pkg::T_IDLE;
						n.resc = 1'b0;
					end
					if (pwdata[afc_pkg::CTRL_COMMIT]) begin
						n.par.apply = 1'b1;
						n.pend = 1'b0;
					end
				end
				afc_pkg::ADDR_SP: n.sp = pwdata[15:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else if (ce) begin
			s <= n;
		end
	end

	assign hin_ready = ce && hin_rdy;
	assign rrx_ready = ce && rrx_rdy;
	assign pready    = ce && s.rok;
	assign pslverr   = psel && penable && paddr != afc_pkg::ADDR_CTRL && paddr != afc_pkg::ADDR_SP
		&& paddr != afc_pkg::ADDR_STAT;
	assign prdata    = s.prdata;
	assign hout      = s.hout;
	assign rtx       = s.rtx;
	assign par       = s.par;
	assign ind_abort = s.abort;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_rx_tok;
		ce && s.mode != afc_pkg::MODE_TRANS && hin.valid && hin_ready && rx_tok;
	endsequence
	sequence s_esc_sent;
		ce && hout_ready && s.hout.valid && s.hout.data == afc_pkg::ESC && s.ts != afc_pkg::T_IDLE
			&& s.mode == afc_pkg::MODE_ESC;
	endsequence
	sequence s_rsp_start;
		ce && s.mode != afc_pkg::MODE_TRANS && !wr_hit && s.ds == afc_pkg::D_RSP && s.ts == afc_pkg::T_IDLE;
	endsequence

	a_trans_pass: assert property (ce && s.mode == afc_pkg::MODE_TRANS && hin.valid && hin_ready
		|=> s.rtx.valid && s.rtx.data == $past(hin.data)) else $error("transparent byte not forwarded");
	a_hunt_drop: assert property (s_rx_tok and (s.rs == afc_pkg::R_HUNT && hin.data != afc_pkg::DELIM)
		|=> s.rs == afc_pkg::R_HUNT && s.ds == afc_pkg::D_IDLE) else $error("byte before delimiter used");
	a_bad_drop: assert property (s_rx_tok and (s.rs == afc_pkg::R_CK && rx_ck != afc_pkg::CK_OK && !wr_hit)
		|=> s.ds == afc_pkg::D_IDLE && s.bad == 8'($past(s.bad) + 8'h01)) else $error("bad frame not dropped");
	a_good_go: assert property (s_rx_tok and (s.rs == afc_pkg::R_CK && rx_ck == afc_pkg::CK_OK && !wr_hit)
		|=> s.ds == afc_pkg::D_GO ##1 s.ds != afc_pkg::D_GO) else $error("good frame not dispatched");
	a_esc_pair: assert property (s_esc_sent |=> s.hout.valid
		&& afc_pkg::need_esc(s.hout.data ^ afc_pkg::ESC_XOR)) else $error("escape not followed by flipped byte");
	a_ck_gen: assert property (ce && otake && s.ts == afc_pkg::T_CK && !esc_now && !wr_hit
		|=> s.hout.valid && s.hout.last && s.hout.data == ($past(s.tesc) ? $past(cur) ^ afc_pkg::ESC_XOR
		: $past(cur))) else $error("checksum byte wrong");
	a_cmd_apply: assert property (s.par.wr && s.ds == afc_pkg::D_RSP && kind == afc_pkg::K_CMD
		|-> s.par.apply && !s.pend) else $error("immediate command not applied");
	a_queue_hold: assert property (s.par.wr && !s.par.apply |-> s.pend) else $error("queued write not pending");
	a_rsp_frame: assert property (s_rsp_start |=> s.ob[0] == afc_pkg::K_CRSP && s.ts == afc_pkg::T_DELIM
		&& s.ds == afc_pkg::D_IDLE) else $error("command response not started");
	a_bcast_st: assert property (ce && txdone.valid && txdone.bcast |=> s.ts_pend
		&& (s.ts_code == afc_pkg::ST_OK || s.ts_code == afc_pkg::ST_BCALT)) else $error("broadcast status illegal");
	a_to_abort: assert property (s.abort |-> s.to_pend && $past(ind_pending))
		else $error("timeout abort without status");
endmodule // afc_codec

// File: dv/afc_host_model.sv
// Host-side model of the serial link: sends framed bytes to the codec and collects its output bytes.
// Assumes the codec's byte handshakes on pclk; the caller starts each transfer just after a rising edge.
`timescale 1ns/10ps
module afc_host_model (
	input  wire logic          pclk,
	output afc_pkg::afc_byte_t hin,
	input  wire logic          hin_ready,
	input  afc_pkg::afc_byte_t hout,
	output logic               hout_ready
);
	logic [7:0] got[$];
	logic       slow;
	initial begin
		hin = '0;
		hout_ready = 1'b1;
		slow = 1'b0;
	end
	// A slow host stalls every other cycle, so the codec must hold each byte until taken.
	always @(posedge pclk) begin
		if (hout.valid && hout_ready)
			got.push_back(hout.data);
		hout_ready <= slow ? ~hout_ready : 1'b1;
	end
	task automatic send(input logic [7:0] b);
		hin <= '{valid: 1'b1, last: 1'b0, data: b};
		do @(posedge pclk); while (hin_ready !== 1'b1);
	endtask
	// Released data shows the inverse of the last byte so no stale value can pass for a good one.
	task automatic idle();
		hin <= '{valid: 1'b0, last: 1'b0, data: ~hin.data};
	endtask
	task automatic put(input logic [1:0] m, input logic [7:0] b);
		if (m == 2'h2 && (b == 8'h7e || b == 8'h7d || b == 8'h11 || b == 8'h13)) begin
			send(8'h7d);
			send(b ^ 8'h20);
		end else
			send(b);
	endtask
	task automatic frame(input logic [1:0] m, input logic [7:0] d[$], input logic bad);
		logic [7:0] s;
		s = 8'h00;
		foreach (d[i]) s += d[i];
		s = 8'hff - s;
		if (bad)
			s = s ^ 8'h01;
		send(8'h7e);
		put(m, 8'(d.size() >> 8));
		put(m, 8'(d.size()));
		foreach (d[i]) put(m, d[i]);
		put(m, s);
	endtask
endmodule // afc_host_model

// File: dv/tb.sv
// Self-checking bench of the serial frame codec: APB setup, host frames, radio traffic, status events.
// Assumes the host model beside it and the codec's package; the radio side is played by this bench.
`timescale 1ns/10ps
module tb;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, rtx_ready, rrx_ready;
	logic hin_ready, ind_pending, ind_abort, err;
	wire  hout_ready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, par_rd_data, rd;
	logic [7:0] ind_fid;
	logic [7:0] rq[$], d1[$], d2[$];
	logic lq[$];
	afc_pkg::afc_byte_t hin, hout, rtx;
	afc_pkg::afc_rrx_t rrx;
	afc_pkg::afc_txd_t txdone;
	afc_pkg::afc_mst_t mstat;
	afc_pkg::afc_par_t par;
	int error_cnt = 0;
	int comparisons = 0;
	int wr_cnt = 0;
	int ap_cnt = 0;
	int ab_cnt = 0;
	logic [47:0] wr_last;
	afc_codec #(.TICK_CYC(10)) dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hin(hin), .hin_ready(hin_ready), .hout(hout), .hout_ready(hout_ready), .rtx(rtx), .rtx_ready(rtx_ready),
		.rrx(rrx), .rrx_ready(rrx_ready), .txdone(txdone), .mstat(mstat), .ind_pending(ind_pending),
		.ind_fid(ind_fid), .ind_abort(ind_abort), .par(par), .par_rd_data(par_rd_data));
	afc_host_model p (.pclk(pclk), .hin(hin), .hin_ready(hin_ready), .hout(hout), .hout_ready(hout_ready));
	// Parameter strobes are one-cycle pulses, so they are counted here rather than polled by the tests.
	always @(posedge pclk) begin
		if (par.wr) begin
			wr_cnt++;
			wr_last <= {par.name, par.val};
		end
		if (par.apply)
			ap_cnt++;
		if (ind_abort) begin
			ab_cnt++;
			ind_pending <= 1'b0;
		end
	end
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// The radio accepts every other cycle, so the codec's output has to wait.
	always @(posedge pclk) begin
		if (rtx.valid && rtx_ready) begin
			rq.push_back(rtx.data);
			lq.push_back(rtx.last);
		end
		rtx_ready <= ~rtx_ready;
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, s, e);
		end
	endtask
	task automatic cmpq(input logic [7:0] s[$], input logic [7:0] e[$]);
		chk(32'(s.size()), 32'(e.size()));
		foreach (e[i]) chk(s[i], e[i]);
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wq(input int n);
		for (int i = 0; i < 600 && rq.size() < n; i++) @(posedge pclk);
		repeat (40) @(posedge pclk);
	endtask
	task automatic wg(input int n);
		for (int i = 0; i < 600 && p.got.size() < n; i++) @(posedge pclk);
		repeat (40) @(posedge pclk);
	endtask
	task automatic rxb(input logic r, input logic [7:0] b);
		@(posedge pclk);
		rrx <= '{valid: 1'b1, src64: 1'b0, io: 1'b0, remote: r, len: 16'h0001, data: b};
		do @(posedge pclk); while (rrx_ready !== 1'b1);
		rrx.valid <= 1'b0;
		rrx.data <= ~b;
	endtask
	task automatic summarize();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		summarize();
	end
	initial begin
		{presetn, psel, penable, pwrite, rtx_ready, ind_pending} = '0;
		{paddr, pwdata, par_rd_data, ind_fid, rrx, txdone, mstat} = '0;
		ce = 1'b1;
		d1 = '{8'h01, 8'h00, 8'hff, 8'hfe, 8'h00, 8'h42};
		d2 = '{8'h00, 8'h01, 8'h7e, 8'h7d, 8'h11, 8'h13, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h7e};
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, afc_pkg::ADDR_CTRL, '0);
		chk(rd[1:0], afc_pkg::MODE_TRANS);
		apb(1'b0, 12'h0f0, '0);
		chk(err, 1'b1);
		@(posedge pclk);
		p.send(8'h7e);
		p.idle();
		wq(1);
		cmpq(rq, '{8'h7e});
		chk(lq[0], 1'b1);
		rq.delete();
		lq.delete();
		apb(1'b1, afc_pkg::ADDR_CTRL, 32'h1);
		// Noise, a corrupted frame and an unknown kind must all vanish before the good frame.
		@(posedge pclk);
		p.send(8'h55);
		p.frame(2'h1, d1, 1'b1);
		p.frame(2'h1, '{8'h23, 8'h11}, 1'b0);
		p.frame(2'h1, d1, 1'b0);
		p.idle();
		wq(6);
		cmpq(rq, d1);
		chk(lq[5], 1'b1);
		rq.delete();
		apb(1'b1, afc_pkg::ADDR_CTRL, 32'h2);
		@(posedge pclk);
		p.frame(2'h2, d2, 1'b0);
		p.idle();
		wq(12);
		cmpq(rq, d2);
		p.slow <= 1'b1;
		rxb(1'b0, 8'h13);
		wg(7);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h02, 8'h81, 8'h7d, 8'h33, 8'h6b});
		p.got.delete();
		txdone <= '{valid: 1'b1, bcast: 1'b0, status: 2'h1, fid: 8'h05};
		@(posedge pclk);
		txdone <= '0;
		wg(7);
		chk(p.got[0], 8'h7e);
		chk(p.got[3], 8'h89);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h03, 8'h89, 8'h05, 8'h01, 8'h70});
		p.got.delete();
		txdone <= '{valid: 1'b1, bcast: 1'b1, status: 2'h1, fid: 8'h06};
		@(posedge pclk);
		txdone <= '0;
		wg(7);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h03, 8'h89, 8'h06, 8'h00, 8'h70});
		p.got.delete();
		mstat <= '{valid: 1'b1, code: 8'h02};
		@(posedge pclk);
		mstat <= '0;
		wg(6);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h02, 8'h8a, 8'h02, 8'h73});
		p.got.delete();
		rxb(1'b1, 8'h55);
		wg(7);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h02, 8'h97, 8'h55, 8'h7d, 8'h33});
		p.got.delete();
		// Each command frame waits for its whole response before the host sends again.
		@(posedge pclk);
		p.frame(2'h2, '{8'h08, 8'h01, 8'h44, 8'h4c, 8'h12, 8'h34}, 1'b0);
		p.idle();
		wg(9);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h05, 8'h88, 8'h01, 8'h44, 8'h4c, 8'h00, 8'he6});
		chk(wr_last[47:32], 32'h0000444c);
		chk(wr_last[31:0], 32'h00001234);
		chk(ap_cnt, 1);
		p.got.delete();
		@(posedge pclk);
		p.frame(2'h2, '{8'h09, 8'h02, 8'h41, 8'h42, 8'h00, 8'h07}, 1'b0);
		p.idle();
		wg(9);
		chk(ap_cnt, 1);
		apb(1'b0, afc_pkg::ADDR_STAT, '0);
		chk(rd[0], 1'b1);
		p.got.delete();
		par_rd_data <= 32'h000000a5;
		@(posedge pclk);
		p.frame(2'h2, '{8'h08, 8'h03, 8'h41, 8'h42}, 1'b0);
		p.idle();
		wg(13);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h09, 8'h88, 8'h03, 8'h41, 8'h42, 8'h00, 8'h00, 8'h00, 8'h00, 8'ha5,
			8'h4c});
		chk(ap_cnt, 2);
		chk(wr_cnt, 2);
		apb(1'b0, afc_pkg::ADDR_STAT, '0);
		chk(rd[0], 1'b0);
		p.got.delete();
		apb(1'b1, afc_pkg::ADDR_SP, 32'h1);
		ind_fid <= 8'h33;
		ind_pending <= 1'b1;
		wg(7);
		cmpq(p.got, '{8'h7e, 8'h00, 8'h03, 8'h89, 8'h33, 8'h03, 8'h40});
		chk(ab_cnt, 1);
		summarize();
	end
endmodule // tb
